// [ddrcke_pkg.sv]
// Package with types and constants for the DDR3 command and clock-enable state decoder
package ddrcke_pkg;

  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 14;
  localparam int BL8_BEATS = 4;
  localparam int BC4_BEATS = 2;
  localparam int RD_LAT = 6;
  localparam int WR_LAT = 5;
  localparam int PRE_CYCLES = 6;
  localparam int REF_CYCLES = 44;
  localparam int XS_CYCLES = 48;
  localparam int XP_CYCLES = 3;
  localparam int MRD_CYCLES = 4;
  localparam int CNT_W = 8;
  localparam logic [NUM_BANKS-1:0] BANKS_RESET = 8'h00;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  typedef enum logic [3:0] {
    CMD_MRS,
    CMD_REF,
    CMD_PRE,
    CMD_ACT,
    CMD_WR,
    CMD_RD,
    CMD_NOP,
    CMD_ZQ,
    CMD_BAD
  } ddrcke_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_READING,
    ST_WRITING,
    ST_PRECHARGING,
    ST_REFRESHING,
    ST_MODESET,
    ST_ACT_PD,
    ST_PRE_PD,
    ST_SELF_REF,
    ST_EXITING
  } ddrcke_state_e;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic cke;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } ddrcke_pins_s;

  typedef struct packed {
    logic valid;
    ddrcke_cmd_e cmd;
    logic [BANK_W-1:0] bank;
    logic autoPre;
    logic chop;
  } ddrcke_act_s;

endpackage

// [ddrcke_bank_table.sv]
// Per-bank open or closed flags
`timescale 1ns/100ps
module ddrcke_bank_table (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Updates
  input wire logic openEn,
  input wire logic closeEn,
  input wire logic closeAll,
  input wire logic [ddrcke_pkg::BANK_W-1:0] bank,
  // State
  output logic [ddrcke_pkg::NUM_BANKS-1:0] openBanks_r
);

  genvar i;
  generate
    for (i = 0; i < ddrcke_pkg::NUM_BANKS; i++) begin : g_bank
      always_ff @(posedge clk) begin
        if (reset) begin
          openBanks_r[i] <= ddrcke_pkg::BANKS_RESET[i];
        end else if (openEn && bank == ddrcke_pkg::BANK_W'(i)) begin
          openBanks_r[i] <= 1'b1;
        end else if (closeAll || (closeEn && bank == ddrcke_pkg::BANK_W'(i))) begin
          openBanks_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// [ddrcke_decoder.sv]
// Command and clock-enable state decoder of a DDR3 memory device
//
// Behaviour
// - Commands decode from chip select, strobes, write enable and CKE at rising edge.
// - Bank inputs pick the target bank, or the mode register for mode set.
// - Started read or write bursts always run to completion uninterrupted.
// - No refresh is performed while in either power-down state.
// - Termination input ignored for state; termination off during self refresh.
// - Self refresh exits when clock enable returns high.
// - A no-operation never terminates an operation still running.
// - Deselect behaves exactly like no-operation.
// - Action chosen from prior state, current command, current and previous CKE.
// - Self refresh entered only from idle by refresh with CKE falling.
// - Power down during burst or precharge picks mode from banks at completion.
// - CKE falling with nop in idle or active: active power down if open, else precharge power down.
// - Idle needs banks closed, no burst and all delays met; the CKE level is not checked.
// - Command and address ignored while CKE stays low in power down.
`timescale 1ns/100ps
module ddrcke_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command pins
  input wire ddrcke_pkg::ddrcke_pins_s pins,
  input wire logic odt,
  // Mode setting
  input wire logic burstChopFixed,
  input wire logic onTheFly,
  // Status
  output ddrcke_pkg::ddrcke_state_e state_r,
  output ddrcke_pkg::ddrcke_act_s action_r,
  output logic [ddrcke_pkg::NUM_BANKS-1:0] openBanks_r,
  output logic refreshActive_r,
  output logic termEnable_r,
  output logic [2:0] modeRegSel_r,
  output logic modeRegWrite_r
);

  // ==========================================
  // Input synchronisers
  ddrcke_pkg::ddrcke_pins_s pinsMeta_r;
  ddrcke_pkg::ddrcke_pins_s pinsSync_r;
  logic odtMeta_r;
  logic odtSync_r;
  logic ckePrev_r;

  always_ff @(posedge clk) begin
    pinsMeta_r <= pins;
    pinsSync_r <= pinsMeta_r;
    odtMeta_r <= odt;
    odtSync_r <= odtMeta_r;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ckePrev_r <= 1'b0;
    end else begin
      ckePrev_r <= pinsSync_r.cke;
    end
  end

  // ==========================================
  // Command decode
  ddrcke_pkg::ddrcke_cmd_e cmd;
  logic ckeNow;
  logic isNop;

  assign ckeNow = pinsSync_r.cke;

  always_comb begin
    cmd = ddrcke_pkg::CMD_NOP;
    if (!pinsSync_r.csN) begin
      case ({pinsSync_r.rasN, pinsSync_r.casN, pinsSync_r.weN})
        3'b000: cmd = ddrcke_pkg::CMD_MRS;
        3'b001: cmd = ddrcke_pkg::CMD_REF;
        3'b010: cmd = ddrcke_pkg::CMD_PRE;
        3'b011: cmd = ddrcke_pkg::CMD_ACT;
        3'b100: cmd = ddrcke_pkg::CMD_WR;
        3'b101: cmd = ddrcke_pkg::CMD_RD;
        3'b110: cmd = ddrcke_pkg::CMD_ZQ;
        3'b111: cmd = ddrcke_pkg::CMD_NOP;
        default: cmd = ddrcke_pkg::CMD_BAD;
      endcase
    end
  end

  assign isNop = (cmd == ddrcke_pkg::CMD_NOP);

  // ==========================================
  // Operation timer and burst bookkeeping
  logic [ddrcke_pkg::CNT_W-1:0] timer_r;
  logic autoPre_r;
  logic [ddrcke_pkg::BANK_W-1:0] burstBank_r;
  logic pdPending_r;
  logic timerDone;
  logic chopNow;
  logic [ddrcke_pkg::CNT_W-1:0] burstLen;

  assign timerDone = (timer_r == '0);
  assign chopNow = onTheFly ? !pinsSync_r.addr[ddrcke_pkg::BC_BIT] : burstChopFixed;
  assign burstLen = chopNow ? ddrcke_pkg::CNT_W'(ddrcke_pkg::BC4_BEATS)
                            : ddrcke_pkg::CNT_W'(ddrcke_pkg::BL8_BEATS);

  // ==========================================
  // State machine
  ddrcke_pkg::ddrcke_state_e stateNxt;
  logic [ddrcke_pkg::CNT_W-1:0] timerNxt;
  logic accept;
  logic openEn;
  logic closeEn;
  logic closeAll;
  logic [ddrcke_pkg::NUM_BANKS-1:0] banksAfter;
  logic anyOpen;

  assign anyOpen = |openBanks_r;
  assign banksAfter = closeAll ? '0 : openBanks_r;

  always_comb begin
    stateNxt = state_r;
    timerNxt = timerDone ? '0 : timer_r - 1'b1;
    accept = 1'b0;
    openEn = 1'b0;
    closeEn = 1'b0;
    closeAll = 1'b0;
    case (state_r)
      ddrcke_pkg::ST_IDLE, ddrcke_pkg::ST_ACTIVE: begin
        if (ckePrev_r && !ckeNow && isNop) begin
          stateNxt = anyOpen ? ddrcke_pkg::ST_ACT_PD : ddrcke_pkg::ST_PRE_PD;
        end else if (ckePrev_r && !ckeNow && cmd == ddrcke_pkg::CMD_REF
                     && state_r == ddrcke_pkg::ST_IDLE && !anyOpen) begin
          stateNxt = ddrcke_pkg::ST_SELF_REF;
        end else if (ckePrev_r && ckeNow && !isNop) begin
          accept = 1'b1;
          case (cmd)
            ddrcke_pkg::CMD_ACT: begin
              openEn = 1'b1;
              stateNxt = ddrcke_pkg::ST_ACTIVE;
            end
            ddrcke_pkg::CMD_PRE: begin
              closeEn = !pinsSync_r.addr[ddrcke_pkg::AP_BIT];
              closeAll = pinsSync_r.addr[ddrcke_pkg::AP_BIT];
              timerNxt = ddrcke_pkg::CNT_W'(ddrcke_pkg::PRE_CYCLES);
              stateNxt = ddrcke_pkg::ST_PRECHARGING;
            end
            ddrcke_pkg::CMD_RD: begin
              timerNxt = ddrcke_pkg::CNT_W'(ddrcke_pkg::RD_LAT) + burstLen;
              stateNxt = ddrcke_pkg::ST_READING;
            end
            ddrcke_pkg::CMD_WR: begin
              timerNxt = ddrcke_pkg::CNT_W'(ddrcke_pkg::WR_LAT) + burstLen;
              stateNxt = ddrcke_pkg::ST_WRITING;
            end
            ddrcke_pkg::CMD_REF: begin
              timerNxt = ddrcke_pkg::CNT_W'(ddrcke_pkg::REF_CYCLES);
              stateNxt = ddrcke_pkg::ST_REFRESHING;
            end
            ddrcke_pkg::CMD_MRS: begin
              timerNxt = ddrcke_pkg::CNT_W'(ddrcke_pkg::MRD_CYCLES);
              stateNxt = ddrcke_pkg::ST_MODESET;
            end
            default: accept = (cmd == ddrcke_pkg::CMD_ZQ);
          endcase
        end
      end
      ddrcke_pkg::ST_READING, ddrcke_pkg::ST_WRITING, ddrcke_pkg::ST_PRECHARGING,
      ddrcke_pkg::ST_REFRESHING, ddrcke_pkg::ST_MODESET: begin
        // Commands during the operation are not taken; the burst is never cut short
        if (timerDone) begin
          closeEn = autoPre_r && (state_r == ddrcke_pkg::ST_READING
                                  || state_r == ddrcke_pkg::ST_WRITING);
          if (pdPending_r || (ckePrev_r && !ckeNow && isNop)) begin
            if (state_r == ddrcke_pkg::ST_REFRESHING) begin
              stateNxt = ddrcke_pkg::ST_PRE_PD;
            end else begin
              stateNxt = ((openBanks_r & ~(closeEn ? (ddrcke_pkg::NUM_BANKS'(1) << burstBank_r)
                           : '0)) != '0) ? ddrcke_pkg::ST_ACT_PD
                                         : ddrcke_pkg::ST_PRE_PD;
            end
          end else begin
            stateNxt = anyOpen && !(closeEn && openBanks_r ==
                         (ddrcke_pkg::NUM_BANKS'(1) << burstBank_r))
                       ? ddrcke_pkg::ST_ACTIVE : ddrcke_pkg::ST_IDLE;
          end
        end
      end
      ddrcke_pkg::ST_ACT_PD, ddrcke_pkg::ST_PRE_PD: begin
        // Inputs other than clock enable are ignored here
        if (!ckePrev_r && ckeNow) begin
          timerNxt = ddrcke_pkg::CNT_W'(ddrcke_pkg::XP_CYCLES);
          stateNxt = ddrcke_pkg::ST_EXITING;
        end
      end
      ddrcke_pkg::ST_SELF_REF: begin
        if (ckeNow) begin
          timerNxt = ddrcke_pkg::CNT_W'(ddrcke_pkg::XS_CYCLES);
          stateNxt = ddrcke_pkg::ST_EXITING;
        end
      end
      ddrcke_pkg::ST_EXITING: begin
        if (timerDone) begin
          stateNxt = anyOpen ? ddrcke_pkg::ST_ACTIVE : ddrcke_pkg::ST_IDLE;
        end
      end
      default: stateNxt = ddrcke_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ddrcke_pkg::ST_IDLE;
      timer_r <= '0;
    end else begin
      state_r <= stateNxt;
      timer_r <= timerNxt;
    end
  end

  // Power-down request seen while an operation is still running
  always_ff @(posedge clk) begin
    if (reset) begin
      pdPending_r <= 1'b0;
    end else if (stateNxt == ddrcke_pkg::ST_ACT_PD || stateNxt == ddrcke_pkg::ST_PRE_PD
                 || stateNxt == ddrcke_pkg::ST_IDLE || stateNxt == ddrcke_pkg::ST_ACTIVE) begin
      pdPending_r <= 1'b0;
    end else if (ckePrev_r && !ckeNow && isNop) begin
      pdPending_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      autoPre_r <= 1'b0;
      burstBank_r <= '0;
    end else if (accept && (cmd == ddrcke_pkg::CMD_RD || cmd == ddrcke_pkg::CMD_WR)) begin
      autoPre_r <= pinsSync_r.addr[ddrcke_pkg::AP_BIT];
      burstBank_r <= pinsSync_r.bank;
    end
  end

  // ==========================================
  // Bank flags
  ddrcke_bank_table u_banks (
    .clk(clk),
    .reset(reset),
    .openEn(openEn),
    .closeEn(closeEn),
    .closeAll(closeAll),
    .bank(accept ? pinsSync_r.bank : burstBank_r),
    .openBanks_r(openBanks_r)
  );

  // ==========================================
  // Outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      action_r <= '{valid: 1'b0, cmd: ddrcke_pkg::CMD_NOP, bank: '0, autoPre: 1'b0, chop: 1'b0};
      modeRegSel_r <= '0;
      modeRegWrite_r <= 1'b0;
    end else begin
      action_r.valid <= accept;
      action_r.cmd <= accept ? cmd : ddrcke_pkg::CMD_NOP;
      action_r.bank <= pinsSync_r.bank;
      action_r.autoPre <= pinsSync_r.addr[ddrcke_pkg::AP_BIT];
      action_r.chop <= chopNow;
      modeRegWrite_r <= accept && cmd == ddrcke_pkg::CMD_MRS;
      if (accept && cmd == ddrcke_pkg::CMD_MRS) begin
        modeRegSel_r <= pinsSync_r.bank;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      refreshActive_r <= 1'b0;
      termEnable_r <= 1'b0;
    end else begin
      refreshActive_r <= (stateNxt == ddrcke_pkg::ST_REFRESHING)
                         || (stateNxt == ddrcke_pkg::ST_SELF_REF);
      termEnable_r <= odtSync_r && stateNxt != ddrcke_pkg::ST_SELF_REF;
    end
  end

endmodule

// [ddrcke_ctrl_model.sv]
// Controller model that drives the command pins of the decoder
`timescale 1ns/100ps
module ddrcke_ctrl_model (
  // Clock
  input wire logic clk,
  // Command pins
  output ddrcke_pkg::ddrcke_pins_s pins
);
  // ==========================================
  // Drivers
  initial pins = '{csN: 1'b1, cke: 1'b1, default: '0};
  // Deselect cycles with CKE at k (send also drives CKE in its command cycle); idle lines toggle
  task automatic idle(input int n, input logic k);
    repeat (n) begin
      @(posedge clk);
      pins <= '{csN: 1'b1, rasN: ~pins.rasN, casN: ~pins.casN, weN: ~pins.weN,
                cke: k, bank: ~pins.bank, addr: ~pins.addr};
    end
  endtask
  // One command, then deselect
  task automatic send(input logic [3:0] c, input logic k, input logic [2:0] b,
                      input logic [13:0] a);
    @(posedge clk);
    pins <= '{csN: c[3], rasN: c[2], casN: c[1], weN: c[0], cke: k, bank: b, addr: a};
    idle(1, k);
  endtask
endmodule

// [ddrcke_decoder_sva.sv]
// Assertions for the command and clock-enable state decoder
`timescale 1ns/100ps
module ddrcke_decoder_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Inputs
  input wire ddrcke_pkg::ddrcke_pins_s pins,
  input wire logic odt,
  input wire logic burstChopFixed,
  input wire logic onTheFly,
  // Outputs
  input wire ddrcke_pkg::ddrcke_state_e state_r,
  input wire ddrcke_pkg::ddrcke_act_s action_r,
  input wire logic [ddrcke_pkg::NUM_BANKS-1:0] openBanks_r,
  input wire logic refreshActive_r,
  input wire logic termEnable_r,
  input wire logic [2:0] modeRegSel_r,
  input wire logic modeRegWrite_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // Properties
  sequence s_fall_nop;
    $fell(pins.cke) && pins.csN;
  endsequence
  sequence s_fall_ref;
    $fell(pins.cke) && !pins.csN && !pins.rasN && !pins.casN && pins.weN;
  endsequence
  property p_pd_entry;
    s_fall_nop ##2 (state_r inside {ddrcke_pkg::ST_ACTIVE, ddrcke_pkg::ST_IDLE}) |=>
      state_r == (openBanks_r != 8'h00 ? ddrcke_pkg::ST_ACT_PD : ddrcke_pkg::ST_PRE_PD);
  endproperty
  property p_sr_entry;
    s_fall_ref ##2 (state_r == ddrcke_pkg::ST_IDLE) |=> state_r == ddrcke_pkg::ST_SELF_REF;
  endproperty
  property p_sr_exit;
    state_r == ddrcke_pkg::ST_SELF_REF && pins.cke |-> ##[1:4] state_r != ddrcke_pkg::ST_SELF_REF;
  endproperty
  property p_rd_burst;
    $rose(state_r == ddrcke_pkg::ST_READING) |-> (state_r == ddrcke_pkg::ST_READING) [*6];
  endproperty
  property p_pd_norefresh;
    state_r inside {ddrcke_pkg::ST_ACT_PD, ddrcke_pkg::ST_PRE_PD} |-> !refreshActive_r;
  endproperty
  property p_sr_term;
    state_r == ddrcke_pkg::ST_SELF_REF ##1 state_r == ddrcke_pkg::ST_SELF_REF |-> !termEnable_r;
  endproperty
  property p_act_decode;
    action_r.valid && action_r.cmd == ddrcke_pkg::CMD_ACT |-> !$past(pins.rasN, 3) &&
      $past(pins.casN, 3) && action_r.bank == $past(pins.bank, 3) && openBanks_r[action_r.bank];
  endproperty
  property p_mrs_sel;
    modeRegWrite_r |-> modeRegSel_r == $past(pins.bank, 3);
  endproperty
  property p_des_nop;
    $past(pins.csN, 3) |-> !action_r.valid;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down entry wrong");
  a_sr_entry: assert property (p_sr_entry) else $error("self refresh not entered");
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh not left");
  a_rd_burst: assert property (p_rd_burst) else $error("read burst cut short");
  a_pd_norefresh: assert property (p_pd_norefresh) else $error("refresh in power down");
  a_sr_term: assert property (p_sr_term) else $error("termination on in self refresh");
  a_act_decode: assert property (p_act_decode) else $error("activate decode wrong");
  a_mrs_sel: assert property (p_mrs_sel) else $error("mode register select wrong");
  a_des_nop: assert property (p_des_nop) else $error("deselect gave an action");
endmodule
bind ddrcke_decoder ddrcke_decoder_sva u_sva (.clk(clk), .reset(reset), .pins(pins), .odt(odt),
  .burstChopFixed(burstChopFixed), .onTheFly(onTheFly), .state_r(state_r), .action_r(action_r),
  .openBanks_r(openBanks_r), .refreshActive_r(refreshActive_r), .termEnable_r(termEnable_r),
  .modeRegSel_r(modeRegSel_r), .modeRegWrite_r(modeRegWrite_r));

// [tb_ddr3_cke_command_state_decoder.sv]
// Testbench for the command and clock-enable state decoder
`timescale 1ns/100ps
module tb_ddr3_cke_command_state_decoder;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic odt = 1'b0;
  logic chopFix = 1'b0;
  logic otf = 1'b0;
  ddrcke_pkg::ddrcke_pins_s pins;
  ddrcke_pkg::ddrcke_state_e st;
  ddrcke_pkg::ddrcke_act_s act;
  logic [7:0] banks;
  logic refAct;
  logic termEn;
  logic [2:0] mrSel;
  logic mrWr;
  int n_mismatch = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  ddrcke_ctrl_model ctrl (.clk(clk), .pins(pins));
  ddrcke_decoder dut (.clk(clk), .reset(reset), .pins(pins), .odt(odt), .burstChopFixed(chopFix),
    .onTheFly(otf), .state_r(st), .action_r(act), .openBanks_r(banks), .refreshActive_r(refAct),
    .termEnable_r(termEn), .modeRegSel_r(mrSel), .modeRegWrite_r(mrWr));
  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_st(input ddrcke_pkg::ddrcke_state_e s);
    int i;
    @(negedge clk);
    for (i = 0; i < 100 && st !== s; i++) @(negedge clk);
    chk("state", 8'(s), 8'(st));
    if (i == 100) end_of_test();
  endtask
  task automatic get_act(output ddrcke_pkg::ddrcke_act_s a);
    a = '0;
    repeat (6) begin
      @(negedge clk);
      if (act.valid === 1'b1) a = act;
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_bank();
    ddrcke_pkg::ddrcke_act_s a;
    ctrl.send(4'h3, 1'b1, 3'h5, 14'h0123);
    get_act(a);
    chk("act cmd", 8'(ddrcke_pkg::CMD_ACT), 8'(a.cmd));
    chk("act bank", 8'h05, 8'(a.bank));
    chk("open", 8'h20, banks);
    ctrl.send(4'h2, 1'b1, 3'h5, 14'h0000);
    wait_st(ddrcke_pkg::ST_IDLE);
    chk("closed", 8'h00, banks);
  endtask
  task automatic t_mrs();
    ddrcke_pkg::ddrcke_act_s a;
    int w;
    w = 0;
    a = '0;
    ctrl.send(4'h0, 1'b1, 3'h3, 14'h0000);
    repeat (6) begin
      @(negedge clk);
      if (mrWr === 1'b1) begin
        w++;
        a = act;
      end
    end
    chk("mr write", 8'h01, 8'(w));
    chk("mr cmd", 8'(ddrcke_pkg::CMD_MRS), 8'(a.cmd));
    chk("mr sel", 8'h03, 8'(mrSel));
    ctrl.idle(6, 1'b1);
  endtask
  task automatic t_nop();
    ddrcke_pkg::ddrcke_act_s a;
    @(posedge clk);
    odt <= 1'b1;
    ctrl.send(4'h7, 1'b1, 3'h0, 14'h0000);
    get_act(a);
    chk("nop valid", 8'h00, 8'(a.valid));
    chk("nop state", 8'(ddrcke_pkg::ST_IDLE), 8'(st));
    chk("term", 8'h01, 8'(termEn));
  endtask
  task automatic t_sr();
    ctrl.send(4'h1, 1'b0, 3'h0, 14'h0000);
    wait_st(ddrcke_pkg::ST_SELF_REF);
    chk("sr refresh", 8'h01, 8'(refAct));
    ctrl.idle(4, 1'b0);
    chk("sr term", 8'h00, 8'(termEn));
    ctrl.idle(1, 1'b1);
    wait_st(ddrcke_pkg::ST_IDLE);
  endtask
  task automatic t_ppd();
    ctrl.idle(4, 1'b0);
    wait_st(ddrcke_pkg::ST_PRE_PD);
    chk("pd refresh", 8'h00, 8'(refAct));
    ctrl.idle(4, 1'b1);
    wait_st(ddrcke_pkg::ST_IDLE);
  endtask
  task automatic t_apd();
    ddrcke_pkg::ddrcke_act_s a;
    ctrl.send(4'h3, 1'b1, 3'h1, 14'h0000);
    ctrl.idle(4, 1'b1);
    ctrl.idle(2, 1'b0);
    wait_st(ddrcke_pkg::ST_ACT_PD);
    ctrl.send(4'h5, 1'b0, 3'h1, 14'h0000);
    get_act(a);
    chk("pd cmd", 8'h00, 8'(a.valid));
    ctrl.idle(1, 1'b1);
    wait_st(ddrcke_pkg::ST_ACTIVE);
    chk("apd open", 8'h02, banks);
  endtask
  task automatic t_burst();
    ctrl.send(4'h5, 1'b1, 3'h1, 14'h0000);
    ctrl.send(4'h2, 1'b1, 3'h1, 14'h0000);
    wait_st(ddrcke_pkg::ST_READING);
    wait_st(ddrcke_pkg::ST_ACTIVE);
    chk("rd open", 8'h02, banks);
    ctrl.send(4'h2, 1'b1, 3'h0, 14'h0400);
    wait_st(ddrcke_pkg::ST_IDLE);
  endtask
  task automatic t_busy();
    ddrcke_pkg::ddrcke_act_s a;
    @(posedge clk);
    otf <= 1'b1;
    ctrl.send(4'h6, 1'b1, 3'h0, 14'h0000);
    get_act(a);
    chk("zq cmd", 8'(ddrcke_pkg::CMD_ZQ), 8'(a.cmd));
    chk("zq state", 8'(ddrcke_pkg::ST_IDLE), 8'(st));
    ctrl.send(4'h3, 1'b1, 3'h2, 14'h0000);
    ctrl.send(4'h4, 1'b1, 3'h2, 14'h0400);
    get_act(a);
    chk("wr cmd", 8'(ddrcke_pkg::CMD_WR), 8'(a.cmd));
    chk("wr chop", 8'h01, 8'(a.chop));
    chk("wr autopre", 8'h01, 8'(a.autoPre));
    wait_st(ddrcke_pkg::ST_IDLE);
    chk("wr closed", 8'h00, banks);
    ctrl.send(4'h1, 1'b1, 3'h0, 14'h0000);
    ctrl.idle(2, 1'b0);
    @(negedge clk);
    chk("ref active", 8'h01, 8'(refAct));
    wait_st(ddrcke_pkg::ST_PRE_PD);
    chk("ref pd refresh", 8'h00, 8'(refAct));
    ctrl.idle(4, 1'b1);
    wait_st(ddrcke_pkg::ST_IDLE);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    ctrl.idle(3, 1'b1);
    t_bank();
    t_mrs();
    t_nop();
    t_sr();
    t_ppd();
    t_apd();
    t_burst();
    t_busy();
    end_of_test();
  end
endmodule
